//--- inc/timer_pkg.sv
// Purpose: shared constants and types of the sixteen bit timer core
// Assumes: byte wide registers on 32-bit word aligned addresses
// Notes: register values sit in data bits 7:0, upper bits read zero
package timer_pkg;
	localparam logic [5:0] OFF_CTRL_A = 6'h00;
	localparam logic [5:0] OFF_CTRL_B = 6'h04;
	localparam logic [5:0] OFF_CNT_L = 6'h08;
	localparam logic [5:0] OFF_CNT_H = 6'h0c;
	localparam logic [5:0] OFF_CMPA_L = 6'h10;
	localparam logic [5:0] OFF_CMPA_H = 6'h14;
	localparam logic [5:0] OFF_CMPB_L = 6'h18;
	localparam logic [5:0] OFF_CMPB_H = 6'h1c;
	localparam logic [5:0] OFF_CAP_L = 6'h20;
	localparam logic [5:0] OFF_CAP_H = 6'h24;
	localparam logic [5:0] OFF_IRQ_MASK = 6'h28;
	localparam logic [5:0] OFF_IRQ_FLAG = 6'h2c;
	localparam logic [5:0] OFF_POWER = 6'h30;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic POWER_RST = 1'b0;
	// interrupt bit order in flag and mask registers
	localparam int IRQ_OVF = 0;
	localparam int IRQ_CMPA = 1;
	localparam int IRQ_CMPB = 2;
	localparam int IRQ_CAP = 3;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] MAX = 16'hffff;
	localparam logic [15:0] TOP8 = 16'h00ff;
	localparam logic [15:0] TOP9 = 16'h01ff;
	localparam logic [15:0] TOP10 = 16'h03ff;
	localparam logic [9:0] DIV8_MASK = 10'h007;
	localparam logic [9:0] DIV64_MASK = 10'h03f;
	localparam logic [9:0] DIV256_MASK = 10'h0ff;
	localparam logic [9:0] DIV1024_MASK = 10'h3ff;
	localparam int FILTER_LEN = 4;
	typedef enum logic [1:0] {SEQ_NORMAL, SEQ_CTC, SEQ_FAST, SEQ_DUAL} seq_t;
	typedef enum logic [2:0] {
		TOP_MAX, TOP_FIX8, TOP_FIX9, TOP_FIX10, TOP_CMPA, TOP_CAP
	} topsel_t;
	typedef enum logic {BUS_IDLE, BUS_ACK} bus_t;
	typedef struct packed {
		logic [1:0] comA;      // ctrl_a 7:6
		logic [1:0] comB;      // ctrl_a 5:4
		logic noiseCancel;     // ctrl_b 7
		logic captureRise;     // ctrl_b 6
		logic captureFromCmp;  // ctrl_b 5
		logic [3:0] wgm;       // ctrl_b 4:3 , ctrl_a 1:0
		logic [2:0] clkSel;    // ctrl_b 2:0
	} ctrl_t;
endpackage

//--- hw/sixteen_bit_timer_core.sv
// Purpose: 16-bit timer/counter with two compare channels and capture
// Assumes: inputs synchronous to core_clk; Avalon-MM slave, 1 wait state
// Notes: 8-bit registers, 16-bit values through a shared high byte latch
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps

module sixteen_bit_timer_core #(
	parameter int CNT_W = 16,
	parameter int FILT_LEN = timer_pkg::FILTER_LEN
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic ext_count_pin,
	input wire logic capture_pin,
	input wire logic cmp_out,
	input wire logic [3:0] irq_ack,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic [3:0] irq
);
	timer_pkg::bus_t busQ;
	timer_pkg::ctrl_t ctrl;
	timer_pkg::seq_t seq;
	timer_pkg::topsel_t topSel;
	logic [7:0] ctrlAQ, ctrlBQ, tempQ, wd;
	logic [3:0] maskQ, flagQ, evt;
	logic powerGateQ;
	logic [CNT_W-1:0] cntQ, cntD, cmpABufQ, cmpBBufQ, cmpAQ, cmpBQ, capQ, top;
	logic [9:0] prescQ;
	logic pinQ, tick, upQ, acc, wrAcc, rdAcc, updCmp;
	logic atBottom, atMax, atTop, cntWr, matchA, matchB;
	logic [FILT_LEN-1:0] filtQ;
	logic trigQ, trigLevel, capEdge, wrapping;

	assign ctrl = {ctrlAQ[7:4], ctrlBQ[7:5], ctrlBQ[4:3], ctrlAQ[1:0],
		ctrlBQ[2:0]};
	assign wd = writedata[7:0];

	// bus slave: one wait state, side effects at the acknowledging edge
	assign waitrequest = (read | write) & (busQ != timer_pkg::BUS_ACK);
	assign acc = (read | write) & (busQ == timer_pkg::BUS_ACK);
	assign wrAcc = acc & write;
	assign rdAcc = acc & read;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busQ <= timer_pkg::BUS_IDLE;
		end else if (busQ == timer_pkg::BUS_IDLE && (read | write)) begin
			busQ <= timer_pkg::BUS_ACK;
		end else begin
			busQ <= timer_pkg::BUS_IDLE;
		end
	end

	// read data is prepared in the wait cycle and stands at the ack edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata <= 32'h0000_0000;
		end else if (read && busQ == timer_pkg::BUS_IDLE) begin
			readdata <= 32'h0000_0000;
			case (address)
				timer_pkg::OFF_CTRL_A: readdata[7:0] <= ctrlAQ;
				timer_pkg::OFF_CTRL_B: readdata[7:0] <= ctrlBQ;
				timer_pkg::OFF_CNT_L: readdata[7:0] <= cntQ[7:0];
				timer_pkg::OFF_CNT_H: readdata[7:0] <= tempQ;
				timer_pkg::OFF_CMPA_L: readdata[7:0] <= cmpABufQ[7:0];
				timer_pkg::OFF_CMPA_H: readdata[7:0] <= cmpABufQ[15:8];
				timer_pkg::OFF_CMPB_L: readdata[7:0] <= cmpBBufQ[7:0];
				timer_pkg::OFF_CMPB_H: readdata[7:0] <= cmpBBufQ[15:8];
				timer_pkg::OFF_CAP_L: readdata[7:0] <= capQ[7:0];
				timer_pkg::OFF_CAP_H: readdata[7:0] <= tempQ;
				timer_pkg::OFF_IRQ_MASK: readdata[3:0] <= maskQ;
				timer_pkg::OFF_IRQ_FLAG: readdata[3:0] <= flagQ;
				timer_pkg::OFF_POWER: readdata[0] <= powerGateQ;
				default: readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlAQ <= timer_pkg::CTRL_RST;
			ctrlBQ <= timer_pkg::CTRL_RST;
			maskQ <= 4'h0;
			powerGateQ <= timer_pkg::POWER_RST;
		end else if (wrAcc) begin
			case (address)
				timer_pkg::OFF_CTRL_A: ctrlAQ <= wd & 8'hf3;
				timer_pkg::OFF_CTRL_B: ctrlBQ <= wd;
				timer_pkg::OFF_IRQ_MASK: maskQ <= wd[3:0];
				timer_pkg::OFF_POWER: powerGateQ <= wd[0];
				default: ;
			endcase
		end
	end

	// one high byte latch shared by all 16-bit registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tempQ <= 8'h00;
		end else if (wrAcc && address[2] && address >= timer_pkg::OFF_CNT_H
			&& address <= timer_pkg::OFF_CAP_H) begin
			tempQ <= wd;
		end else if (rdAcc && address == timer_pkg::OFF_CNT_L) begin
			tempQ <= cntQ[15:8];
		end else if (rdAcc && address == timer_pkg::OFF_CAP_L) begin
			tempQ <= capQ[15:8];
		end
	end

	// mode decode: sequence shape and top source
	always_comb begin
		seq = timer_pkg::SEQ_NORMAL;
		topSel = timer_pkg::TOP_MAX;
		case (ctrl.wgm)
			4'd1: begin seq = timer_pkg::SEQ_DUAL; topSel = timer_pkg::TOP_FIX8; end
			4'd2: begin seq = timer_pkg::SEQ_DUAL; topSel = timer_pkg::TOP_FIX9; end
			4'd3: begin
				seq = timer_pkg::SEQ_DUAL;
				topSel = timer_pkg::TOP_FIX10;
			end
			4'd4: begin seq = timer_pkg::SEQ_CTC; topSel = timer_pkg::TOP_CMPA; end
			4'd5: begin seq = timer_pkg::SEQ_FAST; topSel = timer_pkg::TOP_FIX8; end
			4'd6: begin seq = timer_pkg::SEQ_FAST; topSel = timer_pkg::TOP_FIX9; end
			4'd7: begin
				seq = timer_pkg::SEQ_FAST;
				topSel = timer_pkg::TOP_FIX10;
			end
			4'd8, 4'd10: begin
				seq = timer_pkg::SEQ_DUAL;
				topSel = timer_pkg::TOP_CAP;
			end
			4'd9, 4'd11: begin
				seq = timer_pkg::SEQ_DUAL;
				topSel = timer_pkg::TOP_CMPA;
			end
			4'd12: begin seq = timer_pkg::SEQ_CTC; topSel = timer_pkg::TOP_CAP; end
			4'd14: begin
				seq = timer_pkg::SEQ_FAST;
				topSel = timer_pkg::TOP_CAP;
			end
			4'd15: begin
				seq = timer_pkg::SEQ_FAST;
				topSel = timer_pkg::TOP_CMPA;
			end
			default: ;
		endcase
	end

	always_comb begin
		case (topSel)
			timer_pkg::TOP_FIX8: top = timer_pkg::TOP8;
			timer_pkg::TOP_FIX9: top = timer_pkg::TOP9;
			timer_pkg::TOP_FIX10: top = timer_pkg::TOP10;
			timer_pkg::TOP_CMPA: top = cmpAQ;
			timer_pkg::TOP_CAP: top = capQ;
			default: top = timer_pkg::MAX;
		endcase
	end

	assign atBottom = cntQ == timer_pkg::BOTTOM;
	assign atMax = cntQ == timer_pkg::MAX;
	assign atTop = cntQ == top;

	// clock select; the prescaler is cleared to zero while the power gate is set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescQ <= 10'h000;
			pinQ <= 1'b0;
		end else begin
			prescQ <= powerGateQ ? 10'h000 : prescQ + 10'h001;
			pinQ <= ext_count_pin;
		end
	end

	always_comb begin
		case (ctrl.clkSel)
			3'd1: tick = 1'b1;
			3'd2: tick = (prescQ & timer_pkg::DIV8_MASK) == timer_pkg::DIV8_MASK;
			3'd3: tick = (prescQ & timer_pkg::DIV64_MASK) == timer_pkg::DIV64_MASK;
			3'd4: tick = (prescQ & timer_pkg::DIV256_MASK)
				== timer_pkg::DIV256_MASK;
			3'd5: tick = prescQ == timer_pkg::DIV1024_MASK;
			3'd6: tick = pinQ & ~ext_count_pin;
			3'd7: tick = ~pinQ & ext_count_pin;
			default: tick = 1'b0;
		endcase
		if (powerGateQ) begin
			tick = 1'b0;
		end
	end

	// counter; a software write wins over a tick in the same cycle
	assign cntWr = wrAcc && address == timer_pkg::OFF_CNT_L;
	assign wrapping = seq == timer_pkg::SEQ_NORMAL ? atMax
		: (seq == timer_pkg::SEQ_DUAL ? 1'b0 : atTop);

	always_comb begin
		cntD = cntQ;
		if (cntWr) begin
			cntD = {tempQ, wd};
		end else if (tick) begin
			if (seq == timer_pkg::SEQ_DUAL) begin
				cntD = (upQ && !atTop) || atBottom ? cntQ + 16'h0001
					: cntQ - 16'h0001;
			end else begin
				cntD = wrapping ? timer_pkg::BOTTOM : cntQ + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cntQ <= 16'h0000;
			upQ <= 1'b1;
		end else begin
			cntQ <= cntD;
			if (tick && seq == timer_pkg::SEQ_DUAL && atTop) begin
				upQ <= 1'b0;
			end else if (tick && atBottom) begin
				upQ <= 1'b1;
			end
		end
	end

	// compare buffers: immediate outside PWM, else at top
	always_comb begin
		case (seq)
			timer_pkg::SEQ_FAST: updCmp = tick && atTop;
			timer_pkg::SEQ_DUAL: updCmp = tick && atTop;
			default: updCmp = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmpABufQ <= 16'h0000;
			cmpBBufQ <= 16'h0000;
			cmpAQ <= 16'h0000;
			cmpBQ <= 16'h0000;
		end else begin
			if (wrAcc && address == timer_pkg::OFF_CMPA_L) begin
				cmpABufQ <= {tempQ, wd};
			end
			if (wrAcc && address == timer_pkg::OFF_CMPB_L) begin
				cmpBBufQ <= {tempQ, wd};
			end
			if (updCmp) begin
				cmpAQ <= cmpABufQ;
				cmpBQ <= cmpBBufQ;
			end
		end
	end

	assign matchA = tick && cntQ == cmpAQ;
	assign matchB = tick && cntQ == cmpBQ;

	// waveform generation per channel
	function automatic logic nextWave(input logic cur, input logic [1:0] com,
		input logic hit, input timer_pkg::seq_t s, input logic up,
		input logic restart);
		logic v;
		v = cur;
		if (s == timer_pkg::SEQ_FAST && com[1]) begin
			if (hit) begin
				v = com[0];
			end else if (restart) begin
				v = ~com[0];
			end
		end else if (s == timer_pkg::SEQ_DUAL && com[1]) begin
			if (hit) begin
				v = up ? com[0] : ~com[0];
			end
		end else if (hit) begin
			case (com)
				2'b01: v = ~cur;
				2'b10: v = 1'b0;
				2'b11: v = 1'b1;
				default: v = cur;
			endcase
		end
		return v;
	endfunction

	logic pwmTopA;
	assign pwmTopA = topSel == timer_pkg::TOP_CMPA &&
		(seq == timer_pkg::SEQ_FAST || seq == timer_pkg::SEQ_DUAL);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
		end else begin
			// while channel A also sets the PWM period it can only toggle on match
			if (pwmTopA) begin
				if (matchA && ctrl.comA == 2'b01) begin
					wave_out_a <= ~wave_out_a;
				end
			end else begin
				wave_out_a <= nextWave(wave_out_a, ctrl.comA, matchA, seq, upQ,
					tick && atTop);
			end
			wave_out_b <= nextWave(wave_out_b, ctrl.comB, matchB, seq, upQ,
				tick && atTop);
		end
	end

	// capture trigger, filtered: level must agree over the whole window
	assign trigLevel = ctrl.captureFromCmp ? cmp_out : capture_pin;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			filtQ <= '0;
			trigQ <= 1'b0;
		end else begin
			filtQ <= {filtQ[FILT_LEN-2:0], trigLevel};
			if (!ctrl.noiseCancel) begin
				trigQ <= trigLevel;
			end else if (&filtQ) begin
				trigQ <= 1'b1;
			end else if (~|filtQ) begin
				trigQ <= 1'b0;
			end
		end
	end

	logic trigNow;
	assign trigNow = !ctrl.noiseCancel ? trigLevel
		: (&filtQ ? 1'b1 : (~|filtQ ? 1'b0 : trigQ));
	// capture is off while the capture register sets the top
	assign capEdge = !powerGateQ && topSel != timer_pkg::TOP_CAP &&
		trigNow != trigQ && trigNow == ctrl.captureRise;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			capQ <= 16'h0000;
		end else if (wrAcc && address == timer_pkg::OFF_CAP_L) begin
			capQ <= {tempQ, wd};
		end else if (capEdge) begin
			capQ <= cntQ;
		end
	end

	// interrupt flags: a new event wins over a clear in the same cycle
	assign evt[timer_pkg::IRQ_OVF] = tick && (seq == timer_pkg::SEQ_DUAL
		? atBottom && !upQ : (seq == timer_pkg::SEQ_FAST ? atTop : atMax));
	assign evt[timer_pkg::IRQ_CMPA] = matchA;
	assign evt[timer_pkg::IRQ_CMPB] = matchB;
	assign evt[timer_pkg::IRQ_CAP] = capEdge | (topSel == timer_pkg::TOP_CAP
		&& tick && atTop);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flagQ <= 4'h0;
		end else begin
			flagQ <= (flagQ & ~irq_ack & ~((wrAcc &&
				address == timer_pkg::OFF_IRQ_FLAG) ? wd[3:0] : 4'h0))
				| evt;
		end
	end

	assign irq = flagQ & maskQ;

	stopped_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ctrl.clkSel == 3'd0 && !cntWr) |=> $stable(cntQ))
		else $error("counter moved with no clock source");
	power_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(powerGateQ && !cntWr) |=> cntQ == $past(cntQ))
		else $error("counter moved while power gated");
	match_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(tick && cntQ == cmpBQ) |=> flagQ[timer_pkg::IRQ_CMPB])
		else $error("compare B match did not set its flag");
	flag_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(irq_ack[timer_pkg::IRQ_CMPB] && !evt[timer_pkg::IRQ_CMPB]) |=>
		!flagQ[timer_pkg::IRQ_CMPB])
		else $error("match B flag not cleared by ack");
	capture_latch_a: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		(capEdge && !(wrAcc && address == timer_pkg::OFF_CAP_L))
		|=> capQ == $past(cntQ))
		else $error("capture did not latch the count");
	low_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cntWr |=> cntQ == {$past(tempQ), $past(wd)})
		else $error("low byte write did not merge high latch");
	low_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rdAcc && address == timer_pkg::OFF_CAP_L) |=>
		tempQ == $past(capQ[15:8]))
		else $error("low byte read did not fill high latch");
	max_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(seq == timer_pkg::SEQ_NORMAL && tick && atMax && !cntWr) |=>
		cntQ == timer_pkg::BOTTOM && flagQ[timer_pkg::IRQ_OVF])
		else $error("no wrap and overflow at max");
	irq_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		irq[timer_pkg::IRQ_CMPA] |-> flagQ[1] && maskQ[1])
		else $error("request without flag and enable");
	top_buffer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(seq == timer_pkg::SEQ_FAST && !(tick && atTop)) |=>
		$stable(cmpAQ))
		else $error("active compare A changed mid period");
endmodule

//--- tb/cpu_model.sv
// Purpose: CPU side of the timer, Avalon-MM master and vector acknowledge
// Assumes: one request at a time, answer time taken from waitrequest
// Notes: 16-bit values go high byte first on write, low first on read
`timescale 1ns/1ps
module cpu_model (
	input wire logic core_clk,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	output logic [5:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] irq_ack
);
	initial begin
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		irq_ack = 4'h0;
	end
	task automatic busWrite(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		address <= a;
		writedata <= {24'h000000, d};
		write <= 1'b1;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
		// stale data must not look valid once released
		writedata <= ~{24'h000000, d};
	endtask
	task automatic busRead(input logic [5:0] a, output logic [7:0] d);
		@(posedge core_clk);
		address <= a;
		read <= 1'b1;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		d = readdata[7:0];
		read <= 1'b0;
	endtask
	task automatic wr16(input logic [5:0] aL, input logic [15:0] v);
		busWrite(aL + 6'h04, v[15:8]);
		busWrite(aL, v[7:0]);
	endtask
	task automatic rd16(input logic [5:0] aL, output logic [15:0] v);
		busRead(aL, v[7:0]);
		busRead(aL + 6'h04, v[15:8]);
	endtask
	task automatic ack(input int n);
		@(posedge core_clk);
		irq_ack <= 4'h1 << n;
		@(posedge core_clk);
		irq_ack <= 4'h0;
	endtask
endmodule

//--- tb/test_sixteen_bit_timer_core.sv
// Purpose: self-checking bench of the sixteen bit timer core
// Assumes: design answers every request after one wait cycle or more
// Notes: pin ticks used where exact counts matter, undivided core clock elsewhere
`timescale 1ns/1ps
module test_sixteen_bit_timer_core;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic extCountPin = 1'b0;
	logic capturePin = 1'b0;
	logic cmpOut = 1'b0;
	logic [3:0] irqAck;
	logic waveOutA;
	logic waveOutB;
	logic [3:0] irq;
	logic [15:0] v;
	int miscompares = 0;
	int totalChecks = 0;
	int cycles = 0;
	always #25 core_clk = ~core_clk;
	sixteen_bit_timer_core dut (.core_clk(core_clk), .rst_n(rst_n),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .ext_count_pin(extCountPin),
		.capture_pin(capturePin), .cmp_out(cmpOut), .irq_ack(irqAck),
		.wave_out_a(waveOutA), .wave_out_b(waveOutB), .irq(irq));
	cpu_model cpu (.core_clk(core_clk), .readdata(readdata),
		.waitrequest(waitrequest), .address(address), .read(read),
		.write(write), .writedata(writedata), .irq_ack(irqAck));
	task automatic test_done();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		totalChecks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] b;
		cpu.busRead(a, b);
		chk({8'h00, b}, {8'h00, e});
	endtask
	task automatic rchk16(input logic [5:0] a, input logic [15:0] e);
		logic [15:0] r;
		cpu.rd16(a, r);
		chk(r, e);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk);
			extCountPin <= 1'b1;
			repeat (4) @(posedge core_clk);
			extCountPin <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
	endtask
	task automatic irqChk(input logic [3:0] e);
		@(negedge core_clk);
		chk({12'h000, irq}, {12'h000, e});
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 10000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		rchk(timer_pkg::OFF_CTRL_A, 8'h00);
		rchk(timer_pkg::OFF_CTRL_B, 8'h00);
		rchk(timer_pkg::OFF_POWER, 8'h00);
		rchk(timer_pkg::OFF_IRQ_FLAG, 8'h00);
		irqChk(4'h0);
		$display("test reset done");
		cpu.busWrite(timer_pkg::OFF_CTRL_A, 8'hff);
		rchk(timer_pkg::OFF_CTRL_A, 8'hf3);
		cpu.busWrite(timer_pkg::OFF_CTRL_A, 8'h00);
		cpu.busWrite(6'h34, 8'hff);
		rchk(6'h34, 8'h00);
		rchk(timer_pkg::OFF_CTRL_A, 8'h00);
		$display("test control done");
		cpu.wr16(timer_pkg::OFF_CNT_L, 16'h1234);
		rchk16(timer_pkg::OFF_CNT_L, 16'h1234);
		cpu.wr16(timer_pkg::OFF_CMPA_L, 16'habcd);
		cpu.wr16(timer_pkg::OFF_CMPB_L, 16'h0200);
		cpu.busWrite(timer_pkg::OFF_CNT_H, 8'h55);
		rchk(timer_pkg::OFF_CMPA_H, 8'hab);
		cpu.busWrite(timer_pkg::OFF_CNT_L, 8'h66);
		repeat (30) @(posedge core_clk);
		rchk16(timer_pkg::OFF_CNT_L, 16'h5566);
		rchk16(timer_pkg::OFF_CMPB_L, 16'h0200);
		$display("test latch done");
		cpu.wr16(timer_pkg::OFF_CNT_L, 16'h0000);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h07);
		tick(5);
		rchk16(timer_pkg::OFF_CNT_L, 16'h0005);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h06);
		tick(2);
		rchk16(timer_pkg::OFF_CNT_L, 16'h0007);
		$display("test pin count done");
		cpu.wr16(timer_pkg::OFF_CNT_L, 16'hfffe);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h07);
		tick(2);
		rchk16(timer_pkg::OFF_CNT_L, 16'h0000);
		rchk(timer_pkg::OFF_IRQ_FLAG, 8'h01);
		$display("test wrap done");
		cpu.busWrite(timer_pkg::OFF_IRQ_FLAG, 8'h0f);
		cpu.wr16(timer_pkg::OFF_CNT_L, 16'h00fe);
		cpu.busWrite(timer_pkg::OFF_CTRL_A, 8'h01);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h0f);
		cpu.busWrite(timer_pkg::OFF_IRQ_MASK, 8'h01);
		tick(2);
		rchk16(timer_pkg::OFF_CNT_L, 16'h0000);
		irqChk(4'h1);
		cpu.busWrite(timer_pkg::OFF_IRQ_FLAG, 8'h00);
		rchk(timer_pkg::OFF_IRQ_FLAG, 8'h01);
		cpu.busWrite(timer_pkg::OFF_IRQ_FLAG, 8'h01);
		irqChk(4'h0);
		cpu.busWrite(timer_pkg::OFF_CTRL_A, 8'h00);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h00);
		$display("test fixed top done");
		cpu.wr16(timer_pkg::OFF_CNT_L, 16'h0000);
		cpu.wr16(timer_pkg::OFF_CMPB_L, 16'h0020);
		cpu.wr16(timer_pkg::OFF_CMPA_L, 16'h0030);
		// channel A set on match, channel B toggle on match
		cpu.busWrite(timer_pkg::OFF_CTRL_A, 8'hd0);
		cpu.busWrite(timer_pkg::OFF_IRQ_FLAG, 8'h0f);
		cpu.busWrite(timer_pkg::OFF_IRQ_MASK, 8'h04);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h01);
		repeat (60) @(posedge core_clk);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h00);
		chk({15'h0000, waveOutA}, 16'h0001);
		chk({15'h0000, waveOutB}, 16'h0001);
		irqChk(4'h4);
		cpu.ack(2);
		irqChk(4'h0);
		rchk(timer_pkg::OFF_IRQ_FLAG, 8'h02);
		cpu.busWrite(timer_pkg::OFF_CTRL_A, 8'h00);
		$display("test match done");
		cpu.wr16(timer_pkg::OFF_CNT_L, 16'h0100);
		cpu.busWrite(timer_pkg::OFF_POWER, 8'h01);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h01);
		repeat (20) @(posedge core_clk);
		rchk16(timer_pkg::OFF_CNT_L, 16'h0100);
		cpu.busWrite(timer_pkg::OFF_POWER, 8'h00);
		repeat (20) @(posedge core_clk);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h00);
		cpu.rd16(timer_pkg::OFF_CNT_L, v);
		chk({15'h0000, v > 16'h0100}, 16'h0001);
		$display("test power done");
		cpu.wr16(timer_pkg::OFF_CNT_L, 16'h0777);
		cpu.busWrite(timer_pkg::OFF_IRQ_FLAG, 8'h0f);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'hc0);
		@(posedge core_clk);
		capturePin <= 1'b1;
		@(posedge core_clk);
		capturePin <= 1'b0;
		repeat (10) @(posedge core_clk);
		rchk(timer_pkg::OFF_IRQ_FLAG, 8'h00);
		capturePin <= 1'b1;
		repeat (10) @(posedge core_clk);
		rchk(timer_pkg::OFF_IRQ_FLAG, 8'h08);
		rchk16(timer_pkg::OFF_CAP_L, 16'h0777);
		cpu.busWrite(timer_pkg::OFF_CTRL_B, 8'h60);
		cpu.wr16(timer_pkg::OFF_CNT_L, 16'h0999);
		cmpOut <= 1'b1;
		repeat (5) @(posedge core_clk);
		rchk16(timer_pkg::OFF_CAP_L, 16'h0999);
		$display("test capture done");
		test_done();
	end
endmodule
